// >>> hdl/stp_pkg.sv
// speech test port: shared constants and types
`default_nettype none
package stp_pkg;
    localparam int SAMPLE_BITS    = 13;
    localparam int SAMPLE_RATE_HZ = 8000;
    localparam int BIT_RATE_HZ    = 104000;
    localparam int CLK_HZ         = 100000000;
    localparam int RST_PULSE_MS   = 4;

    // bit clock half period, rounded down
    localparam int HALF_BIT_CYC      = CLK_HZ / (2 * BIT_RATE_HZ);
    localparam int SAMPLE_PERIOD_CYC = CLK_HZ / SAMPLE_RATE_HZ;
    localparam int RST_PULSE_CYC     = RST_PULSE_MS * (CLK_HZ / 1000);

    localparam int CNT_W  = 20;
    localparam int BITS_W = 4;

    // link levels at rest and after reset
    localparam logic CLK_IDLE  = 1'b1;
    localparam logic DATA_IDLE = 1'b0;
    localparam logic [3:0] PIN_SYNC_RST = 4'h2;

    typedef logic [SAMPLE_BITS-1:0] stp_sample_t;

    // {test_ctl1, test_ctl2}
    typedef enum logic [1:0] {
        MODE_NORMAL   = 2'h0,
        MODE_DOWNLINK = 2'h1,
        MODE_UPLINK   = 2'h2,
        MODE_ACOUSTIC = 2'h3
    } stp_mode_t;
endpackage
`default_nettype wire

// >>> hdl/stp_if.sv
// speech test port: link wires between device and tester
`timescale 1ns/100ps
`default_nettype none
interface stp_if;
    logic test_ctl1;
    logic test_ctl2;
    logic port_rst_b;
    logic data_to_dev;
    logic data_from_dev;
    logic data_clk;

    modport device (
        input  test_ctl1,
        input  test_ctl2,
        input  port_rst_b,
        input  data_to_dev,
        output data_from_dev,
        output data_clk
    );

    modport tester (
        output test_ctl1,
        output test_ctl2,
        output port_rst_b,
        output data_to_dev,
        input  data_from_dev,
        input  data_clk
    );
endinterface // stp_if
`default_nettype wire

// >>> hdl/stp_device.sv
// speech test port: handset end, makes the data clock and switches speech paths
//
// Function
// - 13-bit samples, 8000 per second each way
// - full-duplex serial data pair at 104 kbit/s
// - port reset resets the transcoder, in the three test modes only
// - two control lines pick direction and mode
// - handset drives clock, only when data moves
// - speech paths breakable for insert and extract
// - handset obeys the control lines method
// - port reset low asserted, high released
// - two's complement words, msb first
// - sample on rise, change on fall, idle high
// - control pair decodes the four modes
`timescale 1ns/100ps
`default_nettype none
module stp_device #(
    parameter int HALF_CYC   = stp_pkg::HALF_BIT_CYC,
    parameter int SAMPLE_CYC = stp_pkg::SAMPLE_PERIOD_CYC
) (
    // system
    input  wire logic                clk,
    input  wire logic                rst_b,
    // link
    stp_if.device                    link,
    // a/d side
    input  wire stp_pkg::stp_sample_t mic_sample,
    input  wire logic                mic_strobe,
    // speech decoder side
    input  wire stp_pkg::stp_sample_t dec_sample,
    input  wire logic                dec_strobe,
    // speech encoder input
    output stp_pkg::stp_sample_t     enc_sample,
    output logic                     enc_strobe,
    // d/a input
    output stp_pkg::stp_sample_t     spk_sample,
    output logic                     spk_strobe,
    // status
    output logic                     transcoder_rst,
    output stp_pkg::stp_mode_t       test_mode
);
    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} stp_state_t;

    localparam int MSB = stp_pkg::SAMPLE_BITS - 1;

    // pin synchronisers: {ctl1, ctl2, port_rst_b, data}
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_reg <= stp_pkg::PIN_SYNC_RST;
            pin_s2_reg <= stp_pkg::PIN_SYNC_RST;
        end else begin
            pin_s1_reg <= {link.test_ctl1, link.test_ctl2, link.port_rst_b, link.data_to_dev};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    stp_pkg::stp_mode_t mode;
    logic               port_held;
    logic               testing;
    logic               data_in;

    assign mode      = stp_pkg::stp_mode_t'(pin_s2_reg[3:2]);
    assign port_held = !pin_s2_reg[1];
    assign data_in   = pin_s2_reg[0];
    assign testing   = (mode != stp_pkg::MODE_NORMAL);

    // link state
    stp_state_t              st_reg, st_next;
    logic [stp_pkg::CNT_W-1:0]  half_reg, half_next;
    logic [stp_pkg::BITS_W-1:0] bit_reg, bit_next;
    stp_pkg::stp_sample_t    txs_reg, txs_next;
    stp_pkg::stp_sample_t    rxs_reg, rxs_next;
    logic                    dclk_reg, dclk_next;
    logic                    dout_reg, dout_next;
    logic                    done_reg, done_next;
    logic                    start;
    logic                    half_end;

    // path state
    logic [stp_pkg::CNT_W-1:0] tick_reg, tick_next;
    logic                      pend_reg, pend_next;
    stp_pkg::stp_sample_t      out_reg, out_next;
    stp_pkg::stp_sample_t      enc_reg, enc_next;
    logic                      encs_reg, encs_next;
    stp_pkg::stp_sample_t      spk_reg, spk_next;
    logic                      spks_reg, spks_next;
    logic                      trst_reg, trst_next;
    logic                      tick;
    logic                      want;

    assign half_end = (half_reg == stp_pkg::CNT_W'(HALF_CYC - 1));

    // burst engine: one burst carries one word each way
    always_comb begin
        st_next   = st_reg;
        half_next = half_reg + stp_pkg::CNT_W'(1);
        bit_next  = bit_reg;
        txs_next  = txs_reg;
        rxs_next  = rxs_reg;
        dclk_next = dclk_reg;
        dout_next = dout_reg;
        done_next = 1'b0;
        start     = 1'b0;
        if (port_held || !testing) begin
            st_next   = ST_IDLE;
            half_next = '0;
            bit_next  = '0;
            dclk_next = stp_pkg::CLK_IDLE;
            dout_next = stp_pkg::DATA_IDLE;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    half_next = '0;
                    if (pend_reg) begin
                        start     = 1'b1;
                        st_next   = ST_LOW;
                        bit_next  = '0;
                        dclk_next = 1'b0;
                        dout_next = out_reg[MSB];
                        txs_next  = {out_reg[MSB-1:0], 1'b0};
                    end
                end
                ST_LOW: begin
                    if (half_end) begin
                        half_next = '0;
                        dclk_next = 1'b1;
                        rxs_next  = {rxs_reg[MSB-1:0], data_in};
                        bit_next  = bit_reg + stp_pkg::BITS_W'(1);
                        st_next   = ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (half_end) begin
                        half_next = '0;
                        if (bit_reg == stp_pkg::BITS_W'(stp_pkg::SAMPLE_BITS)) begin
                            st_next   = ST_IDLE;
                            done_next = 1'b1;
                        end else begin
                            st_next   = ST_LOW;
                            dclk_next = 1'b0;
                            dout_next = txs_reg[MSB];
                            txs_next  = {txs_reg[MSB-1:0], 1'b0};
                        end
                    end
                end
                default: begin
                    st_next = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg   <= ST_IDLE;
            half_reg <= '0;
            bit_reg  <= '0;
            txs_reg  <= '0;
            rxs_reg  <= '0;
            dclk_reg <= stp_pkg::CLK_IDLE;
            dout_reg <= stp_pkg::DATA_IDLE;
            done_reg <= 1'b0;
        end else begin
            st_reg   <= st_next;
            half_reg <= half_next;
            bit_reg  <= bit_next;
            txs_reg  <= txs_next;
            rxs_reg  <= rxs_next;
            dclk_reg <= dclk_next;
            dout_reg <= dout_next;
            done_reg <= done_next;
        end
    end

    assign tick = (tick_reg == stp_pkg::CNT_W'(SAMPLE_CYC - 1));
    // downlink bursts when a decoded word is ready, others at sample rate
    assign want = (mode == stp_pkg::MODE_DOWNLINK) ? dec_strobe : tick;

    // path switch and burst requests
    always_comb begin
        tick_next = tick ? '0 : tick_reg + stp_pkg::CNT_W'(1);
        pend_next = pend_reg;
        out_next  = out_reg;
        enc_next  = enc_reg;
        encs_next = 1'b0;
        spk_next  = spk_reg;
        spks_next = 1'b0;
        trst_next = port_held && testing;
        if (port_held || !testing) begin
            pend_next = 1'b0;
            tick_next = '0;
        end else if (want) begin
            pend_next = 1'b1; // set wins over start
        end else if (start) begin
            pend_next = 1'b0;
        end
        // extract: decoder words in downlink, a/d words in acoustic
        if (mode == stp_pkg::MODE_DOWNLINK && dec_strobe) begin
            out_next = dec_sample;
        end else if (mode == stp_pkg::MODE_ACOUSTIC && mic_strobe) begin
            out_next = mic_sample;
        end else if (mode == stp_pkg::MODE_UPLINK) begin
            out_next = '0;
        end
        // insert: link words feed the encoder in uplink
        if (mode == stp_pkg::MODE_UPLINK) begin
            encs_next = done_reg;
            if (done_reg) begin
                enc_next = rxs_reg;
            end
        end else begin
            encs_next = mic_strobe;
            if (mic_strobe) begin
                enc_next = mic_sample;
            end
        end
        // insert: link words feed the d/a in acoustic
        if (mode == stp_pkg::MODE_ACOUSTIC) begin
            spks_next = done_reg;
            if (done_reg) begin
                spk_next = rxs_reg;
            end
        end else begin
            spks_next = dec_strobe;
            if (dec_strobe) begin
                spk_next = dec_sample;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_reg <= '0;
            pend_reg <= 1'b0;
            out_reg  <= '0;
            enc_reg  <= '0;
            encs_reg <= 1'b0;
            spk_reg  <= '0;
            spks_reg <= 1'b0;
            trst_reg <= 1'b0;
        end else begin
            tick_reg <= tick_next;
            pend_reg <= pend_next;
            out_reg  <= out_next;
            enc_reg  <= enc_next;
            encs_reg <= encs_next;
            spk_reg  <= spk_next;
            spks_reg <= spks_next;
            trst_reg <= trst_next;
        end
    end

    assign link.data_clk      = dclk_reg;
    assign link.data_from_dev = dout_reg;
    assign enc_sample         = enc_reg;
    assign enc_strobe         = encs_reg;
    assign spk_sample         = spk_reg;
    assign spk_strobe         = spks_reg;
    assign transcoder_rst     = trst_reg;
    assign test_mode          = mode;
endmodule // stp_device
`default_nettype wire

// >>> hdl/stp_tester.sv
// speech test port: test system end, drives controls, reset and its data line
`timescale 1ns/100ps
`default_nettype none
module stp_tester #(
    parameter int RST_CYC = stp_pkg::RST_PULSE_CYC
) (
    // system
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // link
    stp_if.tester                     link,
    // control
    input  wire stp_pkg::stp_mode_t   mode,
    input  wire logic                 reset_req,
    output logic                      reset_busy,
    // words to the handset
    input  wire stp_pkg::stp_sample_t tx_word,
    input  wire logic                 tx_valid,
    output logic                      tx_ready,
    // words from the handset
    output stp_pkg::stp_sample_t      rx_word,
    output logic                      rx_valid
);
    localparam int MSB = stp_pkg::SAMPLE_BITS - 1;
    localparam logic [stp_pkg::BITS_W-1:0] LAST = stp_pkg::BITS_W'(MSB);

    // system domain
    stp_pkg::stp_mode_t         mode_reg;
    logic [stp_pkg::CNT_W-1:0]  rcnt_reg, rcnt_next;
    logic                       prst_reg, prst_next;
    stp_pkg::stp_sample_t       hold_reg, hold_next;
    logic                       full_reg, full_next;
    stp_pkg::stp_sample_t       rxw_reg, rxw_next;
    logic                       rxv_reg, rxv_next;
    logic [2:0]                 take_s_reg, done_s_reg;

    // link domain
    logic                       link_rst_b;
    logic [stp_pkg::BITS_W-1:0] fcnt_reg, fcnt_next;
    stp_pkg::stp_sample_t       txs_reg, txs_next;
    logic                       take_reg, take_next;
    logic [stp_pkg::BITS_W-1:0] rcv_reg, rcv_next;
    stp_pkg::stp_sample_t       rxs_reg, rxs_next;
    stp_pkg::stp_sample_t       word_reg, word_next;
    logic                       done_reg, done_next;

    logic take_seen;
    logic done_seen;

    assign take_seen  = take_s_reg[2] ^ take_s_reg[1];
    assign done_seen  = done_s_reg[2] ^ done_s_reg[1];
    // link side also held while the port reset is driven low
    assign link_rst_b = rst_b & prst_reg;

    always_comb begin
        rcnt_next = rcnt_reg;
        prst_next = prst_reg;
        if (reset_req && prst_reg) begin
            prst_next = 1'b0;
            rcnt_next = '0;
        end else if (!prst_reg) begin
            if (rcnt_reg == stp_pkg::CNT_W'(RST_CYC - 1)) begin
                prst_next = 1'b1;
            end else begin
                rcnt_next = rcnt_reg + stp_pkg::CNT_W'(1);
            end
        end
        hold_next = hold_reg;
        full_next = full_reg;
        if (take_seen) begin
            full_next = 1'b0;
        end
        if (tx_valid && !full_reg) begin
            hold_next = tx_word;
            full_next = 1'b1;
        end
        rxw_next = rxw_reg;
        rxv_next = done_seen;
        if (done_seen) begin
            rxw_next = word_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg   <= stp_pkg::MODE_NORMAL;
            rcnt_reg   <= '0;
            prst_reg   <= 1'b1;
            hold_reg   <= '0;
            full_reg   <= 1'b0;
            rxw_reg    <= '0;
            rxv_reg    <= 1'b0;
            take_s_reg <= '0;
            done_s_reg <= '0;
        end else begin
            mode_reg   <= mode;
            rcnt_reg   <= rcnt_next;
            prst_reg   <= prst_next;
            hold_reg   <= hold_next;
            full_reg   <= full_next;
            rxw_reg    <= rxw_next;
            rxv_reg    <= rxv_next;
            // cleared under port reset: no false toggle
            take_s_reg <= prst_reg ? {take_s_reg[1:0], take_reg} : 3'h0;
            done_s_reg <= prst_reg ? {done_s_reg[1:0], done_reg} : 3'h0;
        end
    end

    // falling edges: first of a burst loads the word, msb out
    always_comb begin
        fcnt_next = (fcnt_reg == LAST) ? '0 : fcnt_reg + stp_pkg::BITS_W'(1);
        take_next = take_reg;
        if (fcnt_reg == '0) begin
            txs_next  = hold_reg;
            take_next = !take_reg;
        end else begin
            txs_next = {txs_reg[MSB-1:0], 1'b0};
        end
    end

    always_ff @(negedge link.data_clk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            fcnt_reg <= '0;
            txs_reg  <= '0;
            take_reg <= 1'b0;
        end else begin
            fcnt_reg <= fcnt_next;
            txs_reg  <= txs_next;
            take_reg <= take_next;
        end
    end

    // rising edges: shift in, thirteenth completes the word
    always_comb begin
        rcv_next  = (rcv_reg == LAST) ? '0 : rcv_reg + stp_pkg::BITS_W'(1);
        rxs_next  = {rxs_reg[MSB-1:0], link.data_from_dev};
        word_next = word_reg;
        done_next = done_reg;
        if (rcv_reg == LAST) begin
            word_next = rxs_next;
            done_next = !done_reg;
        end
    end

    always_ff @(posedge link.data_clk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            rcv_reg  <= '0;
            rxs_reg  <= '0;
            word_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            rcv_reg  <= rcv_next;
            rxs_reg  <= rxs_next;
            word_reg <= word_next;
            done_reg <= done_next;
        end
    end

    assign link.test_ctl1   = mode_reg[1];
    assign link.test_ctl2   = mode_reg[0];
    assign link.port_rst_b  = prst_reg;
    assign link.data_to_dev = txs_reg[MSB];
    assign reset_busy       = !prst_reg;
    assign tx_ready         = !full_reg;
    assign rx_word          = rxw_reg;
    assign rx_valid         = rxv_reg;
endmodule // stp_tester
`default_nettype wire

// >>> bench/stp_sva.sv
// speech test port: link timing checker
`timescale 1ns/100ps
`default_nettype none
module stp_sva #(
    parameter int HALF_CYC = 4,
    parameter int RST_CYC  = 20
) (
    // system
    input wire logic clk,
    input wire logic rst_b,
    // link
    input wire logic test_ctl1,
    input wire logic test_ctl2,
    input wire logic port_rst_b,
    input wire logic data_to_dev,
    input wire logic data_from_dev,
    input wire logic data_clk
);
    logic [7:0]  hi_reg;
    logic [7:0]  hi_next;
    logic [7:0]  lo_reg;
    logic [7:0]  lo_next;
    logic [4:0]  falls_reg;
    logic [4:0]  falls_next;
    logic [15:0] prst_reg;
    logic [15:0] prst_next;
    logic        dclk_reg;
    logic        ok;
    logic        fell;
    logic        gap;

    assign ok   = port_rst_b && (test_ctl1 || test_ctl2);
    assign fell = dclk_reg && !data_clk;
    assign gap  = hi_reg > 8'(HALF_CYC);

    // high and low run lengths, falls in the current burst, port reset length
    always_comb begin
        hi_next    = !data_clk ? 8'h00 : (&hi_reg ? hi_reg : hi_reg + 8'h01);
        lo_next    = data_clk ? 8'h00 : lo_reg + 8'h01;
        prst_next  = port_rst_b ? 16'h0000 : prst_reg + 16'h0001;
        falls_next = falls_reg;
        if (!port_rst_b) begin
            falls_next = 5'h00;
        end else if (fell) begin
            falls_next = gap ? 5'h01 : falls_reg + 5'h01;
        end else if (gap) begin
            falls_next = 5'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hi_reg    <= 8'hFF;
            lo_reg    <= 8'h00;
            falls_reg <= 5'h00;
            prst_reg  <= 16'h0000;
            dclk_reg  <= 1'b1;
        end else begin
            hi_reg    <= hi_next;
            lo_reg    <= lo_next;
            falls_reg <= falls_next;
            prst_reg  <= prst_next;
            dclk_reg  <= data_clk;
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_idle_normal;
        (!test_ctl1 && !test_ctl2) [*8] |-> data_clk;
    endproperty
    a_idle_normal: assert property (p_idle_normal)
        else $error("data clock pulsed in normal mode");

    property p_idle_rst;
        (!port_rst_b) [*6] |-> data_clk && !data_from_dev;
    endproperty
    a_idle_rst: assert property (p_idle_rst)
        else $error("link active during port reset");

    property p_from_stable;
        ok && $past(ok) && !$past(data_clk) |-> $stable(data_from_dev);
    endproperty
    a_from_stable: assert property (p_from_stable)
        else $error("handset data changed while clock low");

    property p_to_stable;
        ok && $past(ok) && !$past(data_clk) |-> $stable(data_to_dev);
    endproperty
    a_to_stable: assert property (p_to_stable)
        else $error("tester data changed while clock low");

    property p_low;
        ok && !dclk_reg && data_clk |-> lo_reg == 8'(HALF_CYC);
    endproperty
    a_low: assert property (p_low)
        else $error("clock low phase wrong length");

    property p_high;
        ok && fell && falls_reg != 5'h00 |-> hi_reg == 8'(HALF_CYC);
    endproperty
    a_high: assert property (p_high)
        else $error("clock high phase wrong length");

    property p_burst;
        ok && hi_reg == 8'(HALF_CYC + 1) && falls_reg != 5'h00 |-> falls_reg == 5'h0D;
    endproperty
    a_burst: assert property (p_burst)
        else $error("burst pulse count wrong");

    property p_rst_len;
        $rose(port_rst_b) |-> prst_reg == 16'(RST_CYC);
    endproperty
    a_rst_len: assert property (p_rst_len)
        else $error("port reset pulse wrong length");

    c_burst: cover property (falls_reg == 5'h0D && hi_reg == 8'(HALF_CYC + 1));
    c_rst: cover property ($rose(port_rst_b));
    c_acoustic: cover property (test_ctl1 && test_ctl2 && fell);
endmodule // stp_sva
`default_nettype wire

// >>> bench/testbench.sv
// speech test port: bench joining handset end and test system end
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int HALF   = 4;
    localparam int SAMPLE = 400;
    localparam int RSTC   = 20;

    logic                 clk;
    logic                 rst_b;
    stp_pkg::stp_sample_t mic_sample;
    logic                 mic_strobe;
    stp_pkg::stp_sample_t dec_sample;
    logic                 dec_strobe;
    stp_pkg::stp_sample_t enc_sample;
    logic                 enc_strobe;
    stp_pkg::stp_sample_t spk_sample;
    logic                 spk_strobe;
    logic                 transcoder_rst;
    stp_pkg::stp_mode_t   test_mode;
    stp_pkg::stp_mode_t   mode;
    logic                 reset_req;
    logic                 reset_busy;
    stp_pkg::stp_sample_t tx_word;
    logic                 tx_valid;
    logic                 tx_ready;
    stp_pkg::stp_sample_t rx_word;
    logic                 rx_valid;
    stp_pkg::stp_sample_t wire_from;
    stp_pkg::stp_sample_t wire_to;
    stp_pkg::stp_sample_t exp_w;
    logic                 dclk_q;
    int                   mismatches;
    int                   checks;
    int                   rx_gap;
    time                  rx_t = 0;
    stp_pkg::stp_sample_t enc_q[$];
    stp_pkg::stp_sample_t spk_q[$];
    stp_pkg::stp_sample_t rx_q[$];

    stp_if link_if();

    stp_device #(.HALF_CYC(HALF), .SAMPLE_CYC(SAMPLE)) stp_device_inst (
        .clk(clk), .rst_b(rst_b), .link(link_if.device),
        .mic_sample(mic_sample), .mic_strobe(mic_strobe),
        .dec_sample(dec_sample), .dec_strobe(dec_strobe),
        .enc_sample(enc_sample), .enc_strobe(enc_strobe),
        .spk_sample(spk_sample), .spk_strobe(spk_strobe),
        .transcoder_rst(transcoder_rst), .test_mode(test_mode)
    );

    stp_tester #(.RST_CYC(RSTC)) stp_tester_inst (
        .clk(clk), .rst_b(rst_b), .link(link_if.tester), .mode(mode),
        .reset_req(reset_req), .reset_busy(reset_busy),
        .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_word(rx_word), .rx_valid(rx_valid)
    );

    stp_sva #(.HALF_CYC(HALF), .RST_CYC(RSTC)) stp_sva_inst (
        .clk(clk), .rst_b(rst_b), .test_ctl1(link_if.test_ctl1),
        .test_ctl2(link_if.test_ctl2), .port_rst_b(link_if.port_rst_b),
        .data_to_dev(link_if.data_to_dev), .data_from_dev(link_if.data_from_dev),
        .data_clk(link_if.data_clk)
    );

    task automatic check(input stp_pkg::stp_sample_t got, input stp_pkg::stp_sample_t exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // waits for a word from the handset, then lets the burst tail settle
    task automatic wait_rx();
        while (rx_valid !== 1'b1) tick(1);
        tick(10);
    endtask

    task automatic send(input stp_pkg::stp_sample_t w);
        while (tx_ready !== 1'b1) tick(1);
        tx_word  = w;
        tx_valid = 1'b1;
        tick(1);
        tx_valid = 1'b0;
    endtask

    task automatic set_mode(input stp_pkg::stp_mode_t m);
        mode = m;
        tick(6);
        check(13'(test_mode), 13'(m));
        check(13'({link_if.test_ctl1, link_if.test_ctl2}), 13'(m));
    endtask

    task automatic port_reset();
        reset_req = 1'b1;
        tick(1);
        reset_req = 1'b0;
        tick(6);
        check(13'(reset_busy), 13'h0001);
        check(13'(transcoder_rst), 13'(mode != stp_pkg::MODE_NORMAL));
        check(13'(link_if.data_clk), 13'h0001);
        while (reset_busy === 1'b1) tick(1);
        tick(4);
        check(13'(transcoder_rst), 13'h0000);
    endtask

    // result watcher: pops the oldest note per output and compares
    always @(negedge clk) begin
        if (link_if.data_clk === 1'b1 && dclk_q === 1'b0) begin
            wire_from = {wire_from[11:0], link_if.data_from_dev};
            wire_to   = {wire_to[11:0], link_if.data_to_dev};
        end
        dclk_q = link_if.data_clk;
        if (enc_strobe === 1'b1 && enc_q.size() > 0) begin
            exp_w = enc_q.pop_front();
            check(enc_sample, exp_w);
            if (mode == stp_pkg::MODE_UPLINK) check(wire_to, exp_w);
        end
        if (spk_strobe === 1'b1 && spk_q.size() > 0) check(spk_sample, spk_q.pop_front());
        if (rx_valid === 1'b1) begin
            rx_gap = int'(($time - rx_t) / 10);
            rx_t   = $time;
            if (rx_q.size() > 0) begin
                exp_w = rx_q.pop_front();
                check(rx_word, exp_w);
                check(wire_from, exp_w);
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    initial begin
        int                   i;
        stp_pkg::stp_sample_t w;
        rst_b      = 1'b0;
        mic_sample = 13'h0000;
        mic_strobe = 1'b0;
        dec_sample = 13'h0000;
        dec_strobe = 1'b0;
        mode       = stp_pkg::MODE_NORMAL;
        reset_req  = 1'b0;
        tx_word    = 13'h0000;
        tx_valid   = 1'b0;
        mismatches = 0;
        checks     = 0;
        dclk_q     = 1'b1;
        void'($urandom(6));
        tick(16);
        rst_b = 1'b1;
        tick(2);
        // normal: back to back pass-through, link idle
        for (i = 0; i < 4; i++) begin
            w          = 13'($urandom);
            mic_sample = w;
            dec_sample = ~w;
            mic_strobe = 1'b1;
            dec_strobe = 1'b1;
            enc_q.push_back(w);
            spk_q.push_back(~w);
            tick(1);
        end
        mic_strobe = 1'b0;
        dec_strobe = 1'b0;
        tick(4);
        check(13'(link_if.data_clk), 13'h0001);
        port_reset();
        set_mode(stp_pkg::MODE_DOWNLINK);
        port_reset();
        for (i = 0; i < 5; i++) begin
            w          = (i == 0) ? 13'h1000 : (i == 1) ? 13'h0FFF : 13'($urandom);
            dec_sample = w;
            dec_strobe = 1'b1;
            spk_q.push_back(w);
            rx_q.push_back(w);
            tick(1);
            dec_strobe = 1'b0;
            wait_rx();
        end
        set_mode(stp_pkg::MODE_UPLINK);
        port_reset();
        wait_rx();
        for (i = 0; i < 5; i++) begin
            w = (i == 0) ? 13'h1001 : 13'($urandom);
            enc_q.push_back(w);
            rx_q.push_back(13'h0000);
            send(w);
            wait_rx();
        end
        // no new word: last one is sent again
        enc_q.push_back(w);
        rx_q.push_back(13'h0000);
        wait_rx();
        check(13'(rx_gap), 13'(SAMPLE));
        while (link_if.data_clk !== 1'b0) tick(1);
        port_reset();
        set_mode(stp_pkg::MODE_ACOUSTIC);
        port_reset();
        wait_rx();
        for (i = 0; i < 4; i++) begin
            w          = 13'($urandom);
            mic_sample = w;
            mic_strobe = 1'b1;
            enc_q.push_back(w);
            rx_q.push_back(w);
            tick(1);
            mic_strobe = 1'b0;
            w          = 13'($urandom);
            spk_q.push_back(w);
            send(w);
            wait_rx();
        end
        set_mode(stp_pkg::MODE_NORMAL);
        tick(20);
        check(13'(link_if.data_clk), 13'h0001);
        check(13'(enc_q.size() + spk_q.size() + rx_q.size()), 13'h0000);
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
